// ---- hdl/udsc_defs.svh ----
// Register offsets, field positions, reset values and timing figures of the USB device port.
// Assumes a 32-bit register port with byte addresses and one word per register.
//
// Functional notes
// - State moves only on bus or requests.
// - Bus reset end sets unmaskable flag, interrupts.
// - Bus reset end restores mask to reset value, clears endpoints.
// - Suspend sets flag, interrupt only if masked.
// - Suspend flag cleared by clear register write.
// - Transceiver disable bit switches transceiver off.
// - Resume detected without clocks, pull-up kept; the port only sees resume through its ref_clk synchronisers.
// - Resume sets wakeup flag, masked interrupt.
// - Endpoint registers at 0x030 and 0x050 strides.
`ifndef UDSC_DEFS_SVH
`define UDSC_DEFS_SVH
`define UDSC_OFS_FRAME 8'h00
`define UDSC_OFS_GLB 8'h04
`define UDSC_OFS_FADDR 8'h08
`define UDSC_OFS_IER 8'h10
`define UDSC_OFS_IDR 8'h14
`define UDSC_OFS_IMR 8'h18
`define UDSC_OFS_ISR 8'h1c
`define UDSC_OFS_ICR 8'h20
`define UDSC_OFS_EPRST 8'h28
`define UDSC_OFS_CSR 8'h30
`define UDSC_OFS_FDR 8'h50
`define UDSC_OFS_TXVC 8'h74
`define UDSC_RST_FADDR 32'h00000100
`define UDSC_RST_IMR 14'h1200
`define UDSC_RST_TXVC 32'h00000100
`define UDSC_BIT_ADDRESS_STATE_ENABLE 0
`define UDSC_BIT_CONFG 1
`define UDSC_BIT_RSMINPR 3
`define UDSC_BIT_FEN 8
`define UDSC_BIT_SUSP 8
`define UDSC_BIT_RSM 9
`define UDSC_BIT_SOF 11
`define UDSC_BIT_EOBR 12
`define UDSC_BIT_WAKE 13
`define UDSC_BIT_TRANSCEIVER_DISABLE 8
`define UDSC_BIT_PULLUP_ON 9
`define UDSC_BIT_TX_COMPLETE 0
`define UDSC_BIT_TX_PACKET_READY 4
`define UDSC_BIT_FRM_ERR 16
`define UDSC_BIT_FRM_OK 17
`define UDSC_CSR_WMASK 32'h0000ff7f
`define UDSC_WAKE_WAIT_MS 5
`endif

// ---- hdl/udsc_pkg.sv ----
// Types shared by the USB device port state controller.
// Assumes the constants header is compiled alongside.
`default_nettype none
package udsc_pkg;
  // Device states seen by the host, plus the suspended state.
  typedef enum logic [2:0] {
    UDSC_POWERED,
    UDSC_DEFAULT,
    UDSC_ADDRESS,
    UDSC_CONFIGURED,
    UDSC_SUSPENDED
  } udsc_state_t;
endpackage
`default_nettype wire

// ---- hdl/udsc_port_state_ctrl.sv ----
// USB device port state controller: register file, device state, endpoint FIFOs.
// Assumes bus-side event pins arrive asynchronously and the endpoint engine shares ref_clk.
`timescale 1ns/1ps
`default_nettype none
`include "udsc_defs.svh"
module udsc_port_state_ctrl import udsc_pkg::*; #(
  parameter int NUM_EP = 6,
  parameter int FIFO_DEPTH = 8
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic bus_reset_end_async,
  input wire logic bus_suspend_async,
  input wire logic bus_resume_async,
  input wire logic send_resume_async,
  input wire logic sof_pulse,
  input wire logic sof_error,
  input wire logic [10:0] sof_frame,
  input wire logic [NUM_EP-1:0] ep_tx_done,
  output logic usb_irq,
  output logic pullup_on,
  output logic transceiver_disable,
  output logic [NUM_EP-1:0] endpoint_fifo_reset,
  output udsc_state_t dev_state
);
  localparam int AW = $clog2(FIFO_DEPTH);

  // Elaboration check: the interrupt registers hold at most six endpoint bits.
  if (NUM_EP < 1 || NUM_EP > 6 || FIFO_DEPTH < 2 || (1 << AW) != FIFO_DEPTH) begin : g_chk
    $error("udsc_port_state_ctrl: unsupported NUM_EP or FIFO_DEPTH");
  end

  // Endpoint register decode, shared by both read and write paths.
  function automatic logic ep_hit(input logic [7:0] a, input logic [7:0] base);
    return (a >= base) && (a < base + 8'(4 * NUM_EP)) && (a[1:0] == 2'b00);
  endfunction
  function automatic logic [2:0] ep_num(input logic [7:0] a, input logic [7:0] base);
    logic [7:0] d;
    d = a - base;
    return d[4:2];
  endfunction

  // Two-flop synchronisers for bus-side pins; edges are taken on the second stage only.
  logic [3:0] sync1_q, sync2_q, prev_q;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
      prev_q <= 4'h0;
    end else begin
      sync1_q <= {send_resume_async, bus_resume_async, bus_suspend_async, bus_reset_end_async};
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end
  logic eobr_ev, susp_ev, resume_ev;
  assign eobr_ev = sync2_q[0] & ~prev_q[0];
  assign susp_ev = sync2_q[1] & ~prev_q[1];
  assign resume_ev = sync2_q[2] & ~prev_q[2];

  // Write strobes per register.
  logic wr_glb, wr_faddr, wr_ier, wr_idr, wr_icr, wr_eprst, wr_txvc, wr_csr, wr_fdr, rd_fdr;
  logic [2:0] wr_ep, rd_ep;
  assign wr_glb = reg_wr && reg_addr == `UDSC_OFS_GLB;
  assign wr_faddr = reg_wr && reg_addr == `UDSC_OFS_FADDR;
  assign wr_ier = reg_wr && reg_addr == `UDSC_OFS_IER;
  assign wr_idr = reg_wr && reg_addr == `UDSC_OFS_IDR;
  assign wr_icr = reg_wr && reg_addr == `UDSC_OFS_ICR;
  assign wr_eprst = reg_wr && reg_addr == `UDSC_OFS_EPRST;
  assign wr_txvc = reg_wr && reg_addr == `UDSC_OFS_TXVC;
  assign wr_csr = reg_wr && ep_hit(reg_addr, `UDSC_OFS_CSR);
  assign wr_fdr = reg_wr && ep_hit(reg_addr, `UDSC_OFS_FDR);
  assign rd_fdr = reg_rd && ep_hit(reg_addr, `UDSC_OFS_FDR);
  assign wr_ep = ep_num(reg_addr, `UDSC_OFS_CSR);
  assign rd_ep = ep_num(reg_addr, `UDSC_OFS_FDR);

  // Device state moves only on bus events or software-issued standard request results.
  udsc_state_t state_q, saved_q, eff_state;
  assign eff_state = (state_q == UDSC_SUSPENDED) ? saved_q : state_q;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= UDSC_POWERED;
      saved_q <= UDSC_POWERED;
    end else if (eobr_ev) begin
      state_q <= UDSC_DEFAULT;
    end else if (susp_ev && state_q != UDSC_SUSPENDED) begin
      saved_q <= state_q;
      state_q <= UDSC_SUSPENDED;
    end else if (resume_ev && state_q == UDSC_SUSPENDED) begin
      state_q <= saved_q;
    end else if (wr_glb) begin
      unique case (state_q)
        UDSC_DEFAULT: if (reg_wdata[`UDSC_BIT_ADDRESS_STATE_ENABLE]) state_q <= UDSC_ADDRESS;
        UDSC_ADDRESS: if (reg_wdata[`UDSC_BIT_CONFG]) state_q <= UDSC_CONFIGURED;
        UDSC_CONFIGURED: if (!reg_wdata[`UDSC_BIT_CONFG]) state_q <= UDSC_ADDRESS;
        UDSC_POWERED, UDSC_SUSPENDED: state_q <= state_q;
      endcase
    end
  end

  // Function address; kept across a bus reset, so software rewrites it after enumeration.
  logic [6:0] faddr_q;
  logic fen_q;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      faddr_q <= 7'(`UDSC_RST_FADDR);
      fen_q <= 1'b1;
    end else if (wr_faddr) begin
      faddr_q <= reg_wdata[6:0];
      fen_q <= reg_wdata[`UDSC_BIT_FEN];
    end
  end

  // Transceiver control; the pull-up stays on through suspend so resume can be seen.
  logic transceiver_disable_q, pullup_on_q;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      transceiver_disable_q <= 1'b1;
      pullup_on_q <= 1'b0;
    end else if (wr_txvc) begin
      transceiver_disable_q <= reg_wdata[`UDSC_BIT_TRANSCEIVER_DISABLE];
      pullup_on_q <= reg_wdata[`UDSC_BIT_PULLUP_ON];
    end
  end

  // Endpoint control words; a bus reset wipes them all.
  logic [31:0] csr_q [NUM_EP];
  logic [NUM_EP-1:0] eprst_q;
  for (genvar e = 0; e < NUM_EP; e++) begin : g_csr
    always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
        csr_q[e] <= 32'h00000000;
      end else if (eobr_ev) begin
        csr_q[e] <= 32'h00000000;
      end else begin
        if (wr_csr && wr_ep == 3'(e)) begin
          csr_q[e] <= reg_wdata & `UDSC_CSR_WMASK;
        end
        // A completion arriving with the clear write still lands.
        if (ep_tx_done[e]) begin
          csr_q[e][`UDSC_BIT_TX_COMPLETE] <= 1'b1;
        end
      end
    end
  end

  // Endpoint reset bits hold the FIFO pointers clear while set.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      eprst_q <= '0;
    end else if (wr_eprst) begin
      eprst_q <= reg_wdata[NUM_EP-1:0];
    end
  end

  // Per-endpoint byte FIFOs; software cancels data by resetting the pointers.
  logic [7:0] fifo_mem [NUM_EP*FIFO_DEPTH];
  logic [AW-1:0] wptr_q [NUM_EP];
  logic [AW-1:0] rptr_q [NUM_EP];
  for (genvar e = 0; e < NUM_EP; e++) begin : g_ptr
    always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
        wptr_q[e] <= '0;
        rptr_q[e] <= '0;
      end else if (eprst_q[e] || eobr_ev) begin
        wptr_q[e] <= '0;
        rptr_q[e] <= '0;
      end else begin
        if (wr_fdr && wr_ep == 3'(e)) wptr_q[e] <= wptr_q[e] + 1'b1;
        if (rd_fdr && rd_ep == 3'(e)) rptr_q[e] <= rptr_q[e] + 1'b1;
      end
    end
  end
  always_ff @(posedge ref_clk) begin
    if (wr_fdr) fifo_mem[{wr_ep, wptr_q[wr_ep]}] <= reg_wdata[7:0];
  end

  // Interrupt mask: set and clear ports, restored on every bus reset.
  logic [13:0] imr_q;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      imr_q <= `UDSC_RST_IMR;
    end else if (eobr_ev) begin
      imr_q <= `UDSC_RST_IMR;
    end else if (wr_ier) begin
      imr_q <= imr_q | reg_wdata[13:0];
    end else if (wr_idr) begin
      imr_q <= imr_q & ~reg_wdata[13:0];
    end
  end

  // Sticky event flags; reading never clears them and a new event beats the clear.
  logic [13:8] evt_q;
  logic [13:8] evt_set;
  always_comb begin
    evt_set = '0;
    evt_set[`UDSC_BIT_SUSP] = susp_ev && state_q != UDSC_SUSPENDED;
    evt_set[`UDSC_BIT_RSM] = resume_ev && state_q == UDSC_SUSPENDED;
    evt_set[`UDSC_BIT_SOF] = sof_pulse;
    evt_set[`UDSC_BIT_EOBR] = eobr_ev;
    evt_set[`UDSC_BIT_WAKE] = resume_ev && state_q == UDSC_SUSPENDED;
  end
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      evt_q <= '0;
    end else begin
      evt_q <= (evt_q & ~(wr_icr ? reg_wdata[13:8] : 6'h00)) | evt_set;
    end
  end

  // Interrupt status: endpoint completions in the low bits, events above.
  logic [13:0] isr;
  always_comb begin
    isr = {evt_q, 8'h00};
    for (int e = 0; e < NUM_EP; e++) begin
      isr[e] = csr_q[e][`UDSC_BIT_TX_COMPLETE];
    end
  end

  // Frame number capture at each start of frame.
  logic [10:0] frame_q;
  logic frm_ok_q, frm_err_q;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      frame_q <= '0;
      frm_ok_q <= 1'b0;
      frm_err_q <= 1'b0;
    end else if (sof_pulse) begin
      frame_q <= sof_frame;
      frm_ok_q <= !sof_error;
      frm_err_q <= sof_error;
    end
  end

  // Read data stand in the cycle after the strobe; unmapped words read as zero.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= '0;
      if (reg_addr == `UDSC_OFS_FRAME) begin
        reg_rdata <= {14'h0000, frm_ok_q, frm_err_q, 5'h00, frame_q};
      end else if (reg_addr == `UDSC_OFS_GLB) begin
        reg_rdata[`UDSC_BIT_ADDRESS_STATE_ENABLE] <= eff_state inside {UDSC_ADDRESS, UDSC_CONFIGURED};
        reg_rdata[`UDSC_BIT_CONFG] <= eff_state == UDSC_CONFIGURED;
        reg_rdata[`UDSC_BIT_RSMINPR] <= sync2_q[3];
      end else if (reg_addr == `UDSC_OFS_FADDR) begin
        reg_rdata <= {23'h000000, fen_q, 1'b0, faddr_q};
      end else if (reg_addr == `UDSC_OFS_IMR) begin
        reg_rdata <= {18'h00000, imr_q};
      end else if (reg_addr == `UDSC_OFS_ISR) begin
        reg_rdata <= {18'h00000, isr};
      end else if (reg_addr == `UDSC_OFS_EPRST) begin
        reg_rdata <= 32'(eprst_q);
      end else if (ep_hit(reg_addr, `UDSC_OFS_CSR)) begin
        reg_rdata <= csr_q[ep_num(reg_addr, `UDSC_OFS_CSR)];
      end else if (rd_fdr) begin
        reg_rdata <= {24'h000000, fifo_mem[{rd_ep, rptr_q[rd_ep]}]};
      end else if (reg_addr == `UDSC_OFS_TXVC) begin
        reg_rdata <= {22'h000000, pullup_on_q, transceiver_disable_q, 8'h00};
      end
    end
  end

  // Registered outputs; the bus reset flag reaches the line regardless of the mask.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      usb_irq <= 1'b0;
      pullup_on <= 1'b0;
      transceiver_disable <= 1'b1;
      endpoint_fifo_reset <= '0;
      dev_state <= UDSC_POWERED;
    end else begin
      usb_irq <= |(isr & imr_q) | isr[`UDSC_BIT_EOBR];
      pullup_on <= pullup_on_q;
      transceiver_disable <= transceiver_disable_q;
      endpoint_fifo_reset <= eprst_q;
      dev_state <= state_q;
    end
  end

  // Checks on the behaviour above.
  property p_eobr_flag;
    @(posedge ref_clk) disable iff (!arst_n) eobr_ev |=> evt_q[`UDSC_BIT_EOBR] ##1 usb_irq;
  endproperty
  a_eobr_flag: assert property (p_eobr_flag) else $error("bus reset flag or irq missing");
  property p_eobr_mask;
    @(posedge ref_clk) disable iff (!arst_n) eobr_ev |=> imr_q == `UDSC_RST_IMR && csr_q[0] == 0;
  endproperty
  a_eobr_mask: assert property (p_eobr_mask) else $error("bus reset left mask or csr");
  property p_susp;
    @(posedge ref_clk) disable iff (!arst_n)
      (susp_ev && !eobr_ev && state_q != UDSC_SUSPENDED)
      |=> evt_q[`UDSC_BIT_SUSP] && state_q == UDSC_SUSPENDED ##1 dev_state == UDSC_SUSPENDED;
  endproperty
  a_susp: assert property (p_susp) else $error("suspend not flagged");
  property p_susp_irq;
    @(posedge ref_clk) disable iff (!arst_n)
      (isr == 14'h0100 && !imr_q[`UDSC_BIT_SUSP]) |=> !usb_irq;
  endproperty
  a_susp_irq: assert property (p_susp_irq) else $error("masked suspend raised irq");
  property p_susp_hold;
    @(posedge ref_clk) disable iff (!arst_n)
      (evt_q[`UDSC_BIT_SUSP] && !(wr_icr && reg_wdata[`UDSC_BIT_SUSP])) |=> evt_q[`UDSC_BIT_SUSP];
  endproperty
  a_susp_hold: assert property (p_susp_hold) else $error("suspend flag lost");
  property p_wake;
    @(posedge ref_clk) disable iff (!arst_n)
      (resume_ev && !eobr_ev && state_q == UDSC_SUSPENDED)
      |=> evt_q[`UDSC_BIT_WAKE] && state_q == $past(saved_q);
  endproperty
  a_wake: assert property (p_wake) else $error("resume not flagged");
  property p_stay_susp;
    @(posedge ref_clk) disable iff (!arst_n)
      (state_q == UDSC_SUSPENDED && !eobr_ev && !resume_ev) |=> state_q == UDSC_SUSPENDED;
  endproperty
  a_stay_susp: assert property (p_stay_susp) else $error("state left suspend");
  property p_ep_rst;
    @(posedge ref_clk) disable iff (!arst_n)
      (wr_eprst && reg_wdata[0]) |=> ##1 wptr_q[0] == 0 && rptr_q[0] == 0 && endpoint_fifo_reset[0];
  endproperty
  a_ep_rst: assert property (p_ep_rst) else $error("endpoint reset kept pointers");
  property p_txv;
    @(posedge ref_clk) disable iff (!arst_n)
      (wr_txvc && reg_wdata[`UDSC_BIT_TRANSCEIVER_DISABLE]) |=> ##1 transceiver_disable && pullup_on == $past(reg_wdata[`UDSC_BIT_PULLUP_ON], 2);
  endproperty
  a_txv: assert property (p_txv) else $error("transceiver disable not applied");
  c_enum: cover property (@(posedge ref_clk) disable iff (!arst_n)
    state_q == UDSC_ADDRESS ##[1:200] state_q == UDSC_CONFIGURED);
  c_susp_wake: cover property (@(posedge ref_clk) disable iff (!arst_n)
    state_q == UDSC_SUSPENDED ##[1:200] evt_q[`UDSC_BIT_WAKE]);
  c_eobr: cover property (@(posedge ref_clk) disable iff (!arst_n) eobr_ev ##1 usb_irq == 1'b0);
endmodule // udsc_port_state_ctrl
`default_nettype wire

// ---- sim/udsc_host_model.sv ----
// Behavioural upstream host: drives bus reset, idle, resume and frame markers into the port.
// Assumes the bench calls its tasks and that ref_clk is the port's own clock.
`timescale 1ns/1ps
`default_nettype none
module udsc_host_model (
  input wire logic ref_clk,
  output logic bus_reset_end_async,
  output logic bus_suspend_async,
  output logic bus_resume_async,
  output logic sof_pulse,
  output logic sof_error,
  output logic [10:0] sof_frame
);
  // Quiet bus at start; frame fields carry junk outside a marker.
  initial begin
    bus_reset_end_async = 1'b0;
    bus_suspend_async = 1'b0;
    bus_resume_async = 1'b0;
    sof_pulse = 1'b0;
    sof_error = 1'b1;
    sof_frame = 11'h7ff;
  end

  // Bus events and software requests move the device; each task here is one bus condition.
  task automatic bus_reset();
    @(posedge ref_clk);
    bus_reset_end_async <= 1'b1;
    repeat (4) @(posedge ref_clk);
    bus_reset_end_async <= 1'b0;
  endtask

  // The idle level stays up for the whole suspend.
  task automatic go_idle();
    @(posedge ref_clk);
    bus_suspend_async <= 1'b1;
  endtask

  // Activity ends the idle level and marks a resume.
  task automatic resume();
    @(posedge ref_clk);
    bus_suspend_async <= 1'b0;
    bus_resume_async <= 1'b1;
    repeat (4) @(posedge ref_clk);
    bus_resume_async <= 1'b0;
  endtask

  // Frame fields are valid only with the pulse; inverted afterwards so stale values show.
  task automatic frame(input logic [10:0] num, input logic err);
    @(posedge ref_clk);
    sof_pulse <= 1'b1;
    sof_error <= err;
    sof_frame <= num;
    @(posedge ref_clk);
    sof_pulse <= 1'b0;
    sof_error <= ~err;
    sof_frame <= ~num;
  endtask
endmodule // udsc_host_model
`default_nettype wire

// ---- sim/udsc_port_state_ctrl_tb.sv ----
// Self-checking bench for the USB device port state controller.
// Assumes the host model owns the bus-side pins and the bench owns the register port.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin mismatches++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, got, exp); end end
module udsc_port_state_ctrl_tb;
  import udsc_pkg::*;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic send_resume_async = 1'b0;
  logic [5:0] ep_tx_done = 6'h0;
  logic [31:0] reg_rdata;
  logic usb_irq, pullup_on, transceiver_disable;
  logic [5:0] endpoint_fifo_reset;
  udsc_state_t dev_state;
  logic bus_reset_end_async, bus_suspend_async, bus_resume_async, sof_pulse, sof_error;
  logic [10:0] sof_frame;
  int mismatches = 0;
  int n_checks = 0;

  always #2.5 ref_clk = ~ref_clk;

  udsc_port_state_ctrl #(.NUM_EP(6), .FIFO_DEPTH(8)) dut (.ref_clk(ref_clk), .arst_n(arst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .bus_reset_end_async(bus_reset_end_async),
    .bus_suspend_async(bus_suspend_async), .bus_resume_async(bus_resume_async),
    .send_resume_async(send_resume_async), .sof_pulse(sof_pulse), .sof_error(sof_error),
    .sof_frame(sof_frame), .ep_tx_done(ep_tx_done), .usb_irq(usb_irq), .pullup_on(pullup_on),
    .transceiver_disable(transceiver_disable), .endpoint_fifo_reset(endpoint_fifo_reset),
    .dev_state(dev_state));

  udsc_host_model host (.ref_clk(ref_clk), .bus_reset_end_async(bus_reset_end_async),
    .bus_suspend_async(bus_suspend_async), .bus_resume_async(bus_resume_async),
    .sof_pulse(sof_pulse), .sof_error(sof_error), .sof_frame(sof_frame));

  // One-cycle write strobe, released at the next edge.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stands from the cycle after the strobe until the next read, so it is sampled there.
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rdata & m, e)
  endtask

  // Event pins pass a synchroniser, so a few cycles are allowed before looking.
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // One-cycle transmit-complete pulse from the endpoint engine.
  task automatic ep_done(input logic [5:0] m);
    @(posedge ref_clk);
    ep_tx_done <= m;
    @(posedge ref_clk);
    ep_tx_done <= 6'h00;
  endtask

  // Reset values of the map and outputs, plus a reserved hole.
  task automatic t_reset_values();
    rd(8'h04, 32'hffffffff, 32'h0);
    rd(8'h08, 32'hffffffff, 32'h100);
    rd(8'h18, 32'hffffffff, 32'h1200);
    rd(8'h28, 32'hffffffff, 32'h0);
    rd(8'h30, 32'hffffffff, 32'h0);
    rd(8'h74, 32'hffffffff, 32'h100);
    wr(8'h0c, 32'hffffffff);
    rd(8'h0c, 32'hffffffff, 32'h0);
    `CHK(transceiver_disable, 1'b1)
    `CHK(dev_state, UDSC_POWERED)
  endtask

  // A clean frame marker loads the number and the good-frame bit.
  task automatic t_frame();
    host.frame(11'h123, 1'b0);
    cyc(2);
    rd(8'h00, 32'hffffffff, 32'h00020123);
    rd(8'h1c, 32'h800, 32'h800);
    wr(8'h20, 32'h800);
  endtask

  // Bus reset end: unmaskable flag, mask and endpoint registers back to reset.
  task automatic t_bus_reset();
    wr(8'h74, 32'h300);
    wr(8'h30, 32'h8000);
    wr(8'h10, 32'h1);
    host.bus_reset();
    cyc(4);
    rd(8'h1c, 32'h1000, 32'h1000);
    `CHK(usb_irq, 1'b1)
    rd(8'h18, 32'hffffffff, 32'h1200);
    rd(8'h30, 32'hffffffff, 32'h0);
    `CHK(dev_state, UDSC_DEFAULT)
    wr(8'h20, 32'h1000);
    cyc(2);
    `CHK(usb_irq, 1'b0)
    `CHK(pullup_on, 1'b1)
    wr(8'h30, 32'h8000);
    wr(8'h10, 32'h1);
    wr(8'h74, 32'h200);
    cyc(1);
    `CHK(transceiver_disable, 1'b0)
  endtask

  // Software walks default, address and configured states.
  task automatic t_states();
    wr(8'h04, 32'h2);
    cyc(1);
    `CHK(dev_state, UDSC_DEFAULT)
    ep_done(6'h01);
    rd(8'h30, 32'h1, 32'h1);
    `CHK(usb_irq, 1'b1)
    wr(8'h30, 32'h8000);
    wr(8'h08, 32'h105);
    rd(8'h08, 32'h17f, 32'h105);
    wr(8'h04, 32'h1);
    cyc(1);
    `CHK(dev_state, UDSC_ADDRESS)
    rd(8'h04, 32'h1, 32'h1);
    wr(8'h04, 32'h3);
    cyc(1);
    `CHK(dev_state, UDSC_CONFIGURED)
    rd(8'h04, 32'h2, 32'h2);
    wr(8'h34, 32'h8600);
    rd(8'h34, 32'hffffffff, 32'h8600);
  endtask

  // Suspend with its mask off: flag sticks through reads, clears only on a clear write.
  task automatic t_suspend();
    host.go_idle();
    cyc(5);
    rd(8'h1c, 32'h100, 32'h100);
    `CHK(usb_irq, 1'b0)
    `CHK(dev_state, UDSC_SUSPENDED)
    rd(8'h1c, 32'h100, 32'h100);
    wr(8'h20, 32'h100);
    rd(8'h1c, 32'h100, 32'h0);
    wr(8'h74, 32'h300);
    cyc(1);
    `CHK(transceiver_disable, 1'b1)
    `CHK(pullup_on, 1'b1)
  endtask

  // Resume with the resume mask off and the wakeup mask on: flag, interrupt, prior state, pull-up kept.
  task automatic t_resume();
    wr(8'h14, 32'h200);
    wr(8'h10, 32'h2000);
    // The port only mirrors the request pin; timing the K state is left to software.
    @(posedge ref_clk);
    send_resume_async <= 1'b1;
    cyc(2);
    rd(8'h04, 32'h8, 32'h8);
    @(posedge ref_clk);
    send_resume_async <= 1'b0;
    cyc(2);
    rd(8'h04, 32'h8, 32'h0);
    host.resume();
    cyc(4);
    rd(8'h1c, 32'h2200, 32'h2200);
    `CHK(usb_irq, 1'b1)
    `CHK(dev_state, UDSC_CONFIGURED)
    `CHK(pullup_on, 1'b1)
    wr(8'h20, 32'h2200);
    cyc(2);
    `CHK(usb_irq, 1'b0)
    wr(8'h74, 32'h200);
    cyc(1);
    `CHK(transceiver_disable, 1'b0)
    `CHK(pullup_on, 1'b1)
  endtask

  // Cancelling transmit data on endpoints 0 and 1.
  task automatic t_endpoints();
    wr(8'h30, 32'h10);
    rd(8'h30, 32'h10, 32'h10);
    wr(8'h30, 32'h0);
    rd(8'h30, 32'h10, 32'h0);
    wr(8'h28, 32'h1);
    cyc(1);
    `CHK(endpoint_fifo_reset, 6'h01)
    wr(8'h28, 32'h0);
    wr(8'h54, 32'ha5);
    wr(8'h54, 32'h3c);
    rd(8'h54, 32'hff, 32'ha5);
    wr(8'h34, 32'h10);
    wr(8'h34, 32'h0);
    rd(8'h34, 32'h10, 32'h0);
    wr(8'h34, 32'h10);
    rd(8'h34, 32'h10, 32'h10);
    wr(8'h34, 32'h0);
    wr(8'h28, 32'h2);
    cyc(1);
    `CHK(endpoint_fifo_reset, 6'h02)
    rd(8'h28, 32'hffffffff, 32'h2);
    wr(8'h28, 32'h0);
    rd(8'h54, 32'hff, 32'ha5);
    ep_done(6'h04);
    rd(8'h38, 32'h1, 32'h1);
  endtask

  // Single exit for both the normal end and the watchdog.
  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // The full sequence needs well under a thousand cycles; this limit is generous.
  initial begin
    repeat (5000) @(posedge ref_clk);
    mismatches++;
    complete_run();
  end

  // Bus reset wipes endpoint registers, so the endpoint scenario runs last.
  initial begin
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
    t_reset_values();
    t_frame();
    t_bus_reset();
    t_states();
    t_suspend();
    t_resume();
    t_endpoints();
    complete_run();
  end
endmodule // udsc_port_state_ctrl_tb
`default_nettype wire
